// [include/plc_pkg.sv]
//--------------------------------------------------------------
// Purpose: Shared constants for the logic cell input front end.
// Assumes: Eight-bit register port, one clock at 20 MHz.
// Notes:   Offsets and field positions are used by design and bench.
//--------------------------------------------------------------
package plc_pkg;

    // ----------------------------------------------------------
    // Structure
    // ----------------------------------------------------------
    localparam int NUM_INPUTS = 16;
    localparam int NUM_LINES = 4;
    localparam int NUM_GATES = 4;
    localparam int SEL_W = 3;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int MUX_GROUP_STEP = 4;
    localparam int RESERVED_IN_A = 10;
    localparam int RESERVED_IN_B = 11;
    localparam int READ_LATENCY = 1;

    // ----------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------
    localparam logic [3:0] REG_CONTROL = 4'h0;
    localparam logic [3:0] REG_SELECT_A = 4'h1;
    localparam logic [3:0] REG_SELECT_B = 4'h2;
    localparam logic [3:0] REG_GATE_POL = 4'h3;
    localparam logic [3:0] REG_GATE1_TERMS = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;

    // ----------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OE_BIT = 6;
    localparam int CTRL_OUT_BIT = 5;
    localparam int CTRL_MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam int SEL_LO_LSB = 0;
    localparam int SEL_HI_LSB = 4;
    localparam int TERM_TRUE_OFS = 0;
    localparam int TERM_INV_OFS = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ----------------------------------------------------------
    // Logic functions of the following stage
    // ----------------------------------------------------------
    typedef enum logic [2:0] {
        PLC_FN_AND_OR,
        PLC_FN_OR_XOR,
        PLC_FN_AND4,
        PLC_FN_SR_LATCH,
        PLC_FN_DFF_SR,
        PLC_FN_DFF_R,
        PLC_FN_JK_R,
        PLC_FN_LATCH_SR
    } plc_mode_t;

endpackage

// [logic/plc_front_end.sv]
//--------------------------------------------------------------
// Purpose: Input selection and data gating of a programmable logic
//          cell, with its software register port.
// Assumes: Generic inputs are synchronous to sys_clk only for the
//          register read path; the gate path itself is combinational.
// Notes:   Select and gate settings have no reset on purpose.
//--------------------------------------------------------------
// Behaviour
// [RL1] Up to sixteen inputs are reduced to four lines for the function stage.
// [RL2] Selection, gating, function and polarity stages reconfigure at run time.
// [RL3] Four independent eight-input multiplexers, each with a 3-bit select.
// [RL4] Four groups of four inputs, each group reaching two differently paired muxes.
// [RL5] Mux one routes inputs 0-7, mux two inputs 4-11, codes ascending.
// [RL6] Mux three routes 8-15; mux four routes 12-15 then 0-3.
// [RL7] Each mux passes only the input named by its select code.
// [RL8] Select, term enable and gate polarity settings are not reset.
// [RL9] Each gate has two enable bits per selected line, one for each form.
// [RL10] Each gate ANDs enabled true and inverted forms of the lines.
// [RL11] Each gate has a polarity control on its result.
// [RL12] A gate with no terms enabled outputs its polarity value.
// [RL13] Gate one follows the 0x55, 0xAA and 0x00 pattern behaviour.
// [RL14] Both forms of one line enabled forces the AND result to zero.
// [RL15] Software should use polarity, not both forms, for constant levels.
// [RL16] Four identical gates, each with its own term enable register.
// [RL17] Gate outputs feed a stage with eight selectable logic functions.
// [RL18] Generic inputs map per instance; inputs 10 and 11 are reserved.
// [RL19] The cell output goes to internal peripherals and to a pin.
// [RL20] A cleared cell enable gives a zero cell output.
// [RL21] Data path is combinational; settings change only by software writes.
`timescale 1ns/1ps

module plc_front_end
    import plc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic [NUM_INPUTS-1:0] generic_inputs,
    output logic selected_line1,
    output logic selected_line2,
    output logic selected_line3,
    output logic selected_line4,
    output logic gate_out1,
    output logic gate_out2,
    output logic gate_out3,
    output logic gate_out4,
    output plc_mode_t func_mode,
    input wire logic func_result,
    output logic cell_out,
    output logic cell_pin_out,
    output logic cell_pin_oe
);

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    function automatic logic reg_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] offset
    );
        return addr == offset;
    endfunction

    // Mux m starts at group m and wraps, so mux four reaches 12-15, 0-3.
    function automatic logic mux_pick(
        input logic [NUM_INPUTS-1:0] src,
        input int m,
        input logic [SEL_W-1:0] sel
    );
        logic [3:0] idx;
        idx = 4'(m * MUX_GROUP_STEP) + {1'b0, sel};
        return src[idx];
    endfunction

    function automatic logic gate_core(
        input logic [DATA_W-1:0] terms,
        input logic [NUM_LINES-1:0] lines
    );
        logic acc;
        acc = 1'b1;
        for (int k = 0; k < NUM_LINES; k++) begin
            if (terms[2*k+TERM_TRUE_OFS]) begin
                acc = acc & lines[k];
            end
            if (terms[2*k+TERM_INV_OFS]) begin
                acc = acc & ~lines[k];
            end
        end
        return acc;
    endfunction

    // ----------------------------------------------------------
    // Configuration state
    // ----------------------------------------------------------
    logic cell_enable_bit;
    logic pin_enable_bit;
    plc_mode_t mode_q;
    logic [SEL_W-1:0] mux_select [NUM_LINES];
    logic [NUM_GATES-1:0] gate_invert;
    logic [DATA_W-1:0] gate_terms [NUM_GATES];
    logic [NUM_INPUTS-1:0] inputs_eff;
    logic [NUM_LINES-1:0] lines;
    logic [NUM_GATES-1:0] gates;

    // Control clears on reset; apart from the read data register, it is the only register that does.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cell_enable_bit <= CTRL_RESET[CTRL_EN_BIT];
            pin_enable_bit <= CTRL_RESET[CTRL_OE_BIT];
            mode_q <= plc_mode_t'(CTRL_RESET[CTRL_MODE_LSB +: MODE_W]);
        end else if (reg_wr && reg_hit(reg_addr, REG_CONTROL)) begin // RL2
            cell_enable_bit <= reg_wdata[CTRL_EN_BIT];
            pin_enable_bit <= reg_wdata[CTRL_OE_BIT];
            mode_q <= plc_mode_t'(reg_wdata[CTRL_MODE_LSB +: MODE_W]); // RL17
        end
    end

    // ----------------------------------------------------------
    // Selection settings
    // ----------------------------------------------------------
    // No reset branch: software must write these before use, and a
    // warm reset leaves a running configuration untouched.
    always_ff @(posedge sys_clk) begin
        if (reg_wr && reg_hit(reg_addr, REG_SELECT_A)) begin // RL8 RL21
            mux_select[0] <= reg_wdata[SEL_LO_LSB +: SEL_W];
            mux_select[1] <= reg_wdata[SEL_HI_LSB +: SEL_W];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reg_wr && reg_hit(reg_addr, REG_SELECT_B)) begin // RL8 RL21
            mux_select[2] <= reg_wdata[SEL_LO_LSB +: SEL_W];
            mux_select[3] <= reg_wdata[SEL_HI_LSB +: SEL_W];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reg_wr && reg_hit(reg_addr, REG_GATE_POL)) begin // RL8 RL11
            gate_invert <= reg_wdata[NUM_GATES-1:0];
        end
    end

    // ----------------------------------------------------------
    // Selection and gating path
    // ----------------------------------------------------------
    // Reserved inputs read as zero so an unused code is harmless.
    always_comb begin
        inputs_eff = generic_inputs; // RL1 RL18
        inputs_eff[RESERVED_IN_A] = 1'b0; // RL18
        inputs_eff[RESERVED_IN_B] = 1'b0; // RL18
    end

    for (genvar g = 0; g < NUM_GATES; g++) begin : g_lane
        always_ff @(posedge sys_clk) begin
            if (reg_wr && reg_hit(reg_addr, ADDR_W'(REG_GATE1_TERMS + g))) begin // RL16
                gate_terms[g] <= reg_wdata; // RL8 RL9
            end
        end

        // Each mux sees only its eight inputs; the select names one.
        assign lines[g] = mux_pick(inputs_eff, g, mux_select[g]); // RL3 RL4 RL7

        // A set polarity bit passes the AND result, a clear one inverts it;
        // this gives AND for 0x55 and NOR for 0xAA with polarity set.
        assign gates[g] = gate_invert[g] ? gate_core(gate_terms[g], lines) // RL14
                                         : ~gate_core(gate_terms[g], lines); // RL10 RL12 RL13
    end

    assign selected_line1 = lines[0]; // RL5
    assign selected_line2 = lines[1]; // RL5
    assign selected_line3 = lines[2]; // RL6
    assign selected_line4 = lines[3]; // RL6
    assign gate_out1 = gates[0]; // RL21
    assign gate_out2 = gates[1];
    assign gate_out3 = gates[2];
    assign gate_out4 = gates[3];
    assign func_mode = mode_q; // RL17

    // ----------------------------------------------------------
    // Cell output
    // ----------------------------------------------------------
    // The function stage result is held at zero while disabled, both
    // towards the peripherals and towards the pin.
    assign cell_out = cell_enable_bit & func_result; // RL20 RL19
    assign cell_pin_out = cell_out; // RL19
    assign cell_pin_oe = pin_enable_bit; // RL19

    // ----------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            reg_rdata <= READ_UNMAPPED;
        end else if (reg_rd) begin
            if (reg_hit(reg_addr, REG_CONTROL)) begin
                reg_rdata <= READ_UNMAPPED;
                reg_rdata[CTRL_EN_BIT] <= cell_enable_bit;
                reg_rdata[CTRL_OE_BIT] <= pin_enable_bit;
                reg_rdata[CTRL_OUT_BIT] <= cell_out;
                reg_rdata[CTRL_MODE_LSB +: MODE_W] <= mode_q;
            end else if (reg_hit(reg_addr, REG_SELECT_A)) begin
                reg_rdata <= READ_UNMAPPED;
                reg_rdata[SEL_LO_LSB +: SEL_W] <= mux_select[0];
                reg_rdata[SEL_HI_LSB +: SEL_W] <= mux_select[1];
            end else if (reg_hit(reg_addr, REG_SELECT_B)) begin
                reg_rdata <= READ_UNMAPPED;
                reg_rdata[SEL_LO_LSB +: SEL_W] <= mux_select[2];
                reg_rdata[SEL_HI_LSB +: SEL_W] <= mux_select[3];
            end else if (reg_hit(reg_addr, REG_GATE_POL)) begin
                reg_rdata <= {4'h0, gate_invert};
            end else if (reg_addr >= REG_GATE1_TERMS && reg_addr < REG_STATUS) begin
                reg_rdata <= gate_terms[reg_addr[1:0]];
            end else if (reg_hit(reg_addr, REG_STATUS)) begin
                reg_rdata <= {gates, lines};
            end else begin
                reg_rdata <= READ_UNMAPPED;
            end
        end else begin
            reg_rdata <= READ_UNMAPPED;
        end
    end

    // ----------------------------------------------------------
    // Checks
    // ----------------------------------------------------------
    property p_mux1_route;
        @(posedge sys_clk) disable iff (!rstn)
        mux_select[0] == 3'h7 |-> selected_line1 == generic_inputs[7];
    endproperty
    a_mux1_route: assert property (p_mux1_route) // RL5
        else $error("mux one code 7 does not pass input 7");

    property p_mux2_route;
        @(posedge sys_clk) disable iff (!rstn)
        mux_select[1] == 3'h0 |-> selected_line2 == generic_inputs[4];
    endproperty
    a_mux2_route: assert property (p_mux2_route) // RL5
        else $error("mux two code 0 does not pass input 4");

    property p_mux4_wrap;
        @(posedge sys_clk) disable iff (!rstn)
        mux_select[3] == 3'h5 |-> selected_line4 == generic_inputs[1];
    endproperty
    a_mux4_wrap: assert property (p_mux4_wrap) // RL6
        else $error("mux four code 5 does not pass input 1");

    property p_mux3_reserved;
        @(posedge sys_clk) disable iff (!rstn)
        mux_select[2] == 3'h2 |-> selected_line3 == 1'b0;
    endproperty
    a_mux3_reserved: assert property (p_mux3_reserved) // RL18
        else $error("reserved input 10 is not zero");

    property p_gate_const;
        @(posedge sys_clk) disable iff (!rstn)
        gate_terms[0] == 8'h00 |-> gate_out1 == gate_invert[0];
    endproperty
    a_gate_const: assert property (p_gate_const) // RL12
        else $error("gate one without terms differs from its polarity");

    property p_gate_and;
        @(posedge sys_clk) disable iff (!rstn)
        (gate_terms[0] == 8'h55 && gate_invert[0])
            |-> gate_out1 == (&lines);
    endproperty
    a_gate_and: assert property (p_gate_and) // RL13
        else $error("gate one pattern 55 is not an AND");

    property p_gate_or;
        @(posedge sys_clk) disable iff (!rstn)
        (gate_terms[1] == 8'hAA && !gate_invert[1])
            |-> gate_out2 == (|lines);
    endproperty
    a_gate_or: assert property (p_gate_or) // RL13
        else $error("gate two pattern AA without polarity is not an OR");

    property p_both_forms;
        @(posedge sys_clk) disable iff (!rstn)
        (gate_terms[2][1:0] == 2'h3 && gate_invert[2]) |-> gate_out3 == 1'b0;
    endproperty
    a_both_forms: assert property (p_both_forms) // RL14
        else $error("both forms of line one do not force gate three low");

    property p_disabled_zero;
        @(posedge sys_clk) disable iff (!rstn)
        !cell_enable_bit |-> !cell_out && !cell_pin_out;
    endproperty
    a_disabled_zero: assert property (p_disabled_zero) // RL20
        else $error("disabled cell drives a one");

    property p_select_write;
        @(posedge sys_clk) disable iff (!rstn)
        (reg_wr && reg_addr == REG_SELECT_B)
            |=> mux_select[3] == $past(reg_wdata[6:4]);
    endproperty
    a_select_write: assert property (p_select_write) // RL21
        else $error("mux four select not taken from write");

    property p_read_status;
        @(posedge sys_clk) disable iff (!rstn)
        (reg_rd && reg_addr == REG_STATUS)
            |=> reg_rdata == $past({gates, lines});
    endproperty
    a_read_status: assert property (p_read_status) // RL2
        else $error("status read one cycle later is wrong");

    property p_rdata_idle;
        @(posedge sys_clk) disable iff (!rstn)
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) // RL21
        else $error("read data not zero outside a read answer");

    property p_mux3_top;
        @(posedge sys_clk) disable iff (!rstn)
        mux_select[2] == 3'h7 |-> selected_line3 == generic_inputs[15];
    endproperty
    a_mux3_top: assert property (p_mux3_top) // RL6
        else $error("mux three code 7 does not pass input 15");

    property p_mux4_first;
        @(posedge sys_clk) disable iff (!rstn)
        mux_select[3] == 3'h0 |-> selected_line4 == generic_inputs[12];
    endproperty
    a_mux4_first: assert property (p_mux4_first) // RL6
        else $error("mux four code 0 does not pass input 12");

    property p_mux2_reserved;
        @(posedge sys_clk) disable iff (!rstn)
        mux_select[1] == 3'h7 |-> selected_line2 == 1'b0;
    endproperty
    a_mux2_reserved: assert property (p_mux2_reserved) // RL18
        else $error("reserved input 11 is not zero");

    property p_gate_nand;
        @(posedge sys_clk) disable iff (!rstn)
        (gate_terms[0] == 8'h55 && !gate_invert[0]) |-> gate_out1 == ~(&lines);
    endproperty
    a_gate_nand: assert property (p_gate_nand) // RL13
        else $error("gate one pattern 55 without polarity is not a NAND");

    property p_gate_nor;
        @(posedge sys_clk) disable iff (!rstn)
        (gate_terms[1] == 8'hAA && gate_invert[1]) |-> gate_out2 == ~(|lines);
    endproperty
    a_gate_nor: assert property (p_gate_nor) // RL13
        else $error("gate two pattern AA with polarity is not a NOR");

    property p_enabled_pass;
        @(posedge sys_clk) disable iff (!rstn)
        cell_enable_bit |-> cell_out == func_result;
    endproperty
    a_enabled_pass: assert property (p_enabled_pass) // RL20
        else $error("enabled cell does not pass the function result");

    property p_unmapped_read;
        @(posedge sys_clk) disable iff (!rstn)
        (reg_rd && reg_addr > REG_STATUS) |=> reg_rdata == READ_UNMAPPED;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) // RL21
        else $error("unmapped index does not read zero");

    property p_control_read;
        @(posedge sys_clk) disable iff (!rstn)
        (reg_rd && reg_addr == REG_CONTROL)
            |=> reg_rdata[4:3] == 2'h0 && reg_rdata[CTRL_EN_BIT] == $past(cell_enable_bit);
    endproperty
    a_control_read: assert property (p_control_read) // RL2
        else $error("control read shows wrong enable or reserved bits");

    property p_terms_write;
        @(posedge sys_clk) disable iff (!rstn)
        (reg_wr && reg_addr == REG_GATE1_TERMS) |=> gate_terms[0] == $past(reg_wdata);
    endproperty
    a_terms_write: assert property (p_terms_write) // RL16
        else $error("gate one term enables not taken from write");

endmodule

// [tb/plc_func_model.sv]
// Purpose: Stand-in for the logic function stage behind the gates.
// Assumes: Only the combinational functions are modelled exactly.
// Notes:   Latching modes pass gate one through, so no state is kept.
`timescale 1ns/1ps

module plc_func_model
    import plc_pkg::*;
(
    input wire plc_mode_t func_mode,
    input wire logic [3:0] gate_in,
    output logic func_result
);
    always_comb begin
        case (func_mode)
            PLC_FN_AND_OR: func_result = (gate_in[0] & gate_in[1]) | (gate_in[2] & gate_in[3]);
            PLC_FN_OR_XOR: func_result = (gate_in[0] | gate_in[1]) ^ (gate_in[2] | gate_in[3]);
            PLC_FN_AND4: func_result = &gate_in;
            default: func_result = gate_in[0];
        endcase
    end
endmodule

// [tb/tb.sv]
// Purpose: Self-checking bench for the logic cell front end.
// Assumes: Register port answers reads one cycle after the strobe.
// Notes:   Data inputs change on the clock edge and are checked at the falling edge.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end

module tb
    import plc_pkg::*;
();
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [NUM_INPUTS-1:0] gin = '0;
    logic [3:0] line;
    logic [3:0] gate;
    plc_mode_t func_mode;
    logic func_result, cell_out, cell_pin_out, cell_pin_oe;
    int n_mismatch = 0;
    int comparisons = 0;
    int seed_val;
    logic [7:0] d;
    logic [2:0] sel [4];
    logic [7:0] terms [4];
    logic [3:0] pol;
    logic [7:0] ctrl;
    logic [7:0] pat [4] = '{8'h55, 8'hAA, 8'h00, 8'hFF};

    always #25 sys_clk = ~sys_clk;

    plc_front_end u_plc_front_end (
        .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .generic_inputs(gin),
        .selected_line1(line[0]), .selected_line2(line[1]),
        .selected_line3(line[2]), .selected_line4(line[3]),
        .gate_out1(gate[0]), .gate_out2(gate[1]), .gate_out3(gate[2]), .gate_out4(gate[3]),
        .func_mode(func_mode), .func_result(func_result), .cell_out(cell_out),
        .cell_pin_out(cell_pin_out), .cell_pin_oe(cell_pin_oe)
    );

    plc_func_model u_plc_func_model (
        .func_mode(func_mode), .gate_in(gate), .func_result(func_result)
    );

    // ----------------------------------------------------------
    // Expectations
    // ----------------------------------------------------------
    function automatic logic [3:0] exp_lines(logic [15:0] g);
        logic [15:0] m;
        m = g & ~16'h0C00;
        for (int k = 0; k < 4; k++) begin
            exp_lines[k] = m[(4 * k + sel[k]) % 16];
        end
    endfunction

    function automatic logic exp_gate(int g, logic [3:0] l);
        logic a;
        a = 1'b1;
        for (int k = 0; k < 4; k++) begin
            a &= (~terms[g][2 * k] | l[k]) & (~terms[g][2 * k + 1] | ~l[k]);
        end
        return pol[g] ? a : ~a;
    endfunction

    function automatic logic exp_fn(logic [2:0] m, logic [3:0] g);
        case (plc_mode_t'(m))
            PLC_FN_AND_OR: return (g[0] & g[1]) | (g[2] & g[3]);
            PLC_FN_OR_XOR: return (g[0] | g[1]) ^ (g[2] | g[3]);
            PLC_FN_AND4: return &g;
            default: return g[0];
        endcase
    endfunction

    // ----------------------------------------------------------
    // Bus tasks and checks
    // ----------------------------------------------------------
    task automatic wr(logic [3:0] a, logic [7:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [3:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic cfg();
        wr(REG_SELECT_A, {1'b0, sel[1], 1'b0, sel[0]});
        wr(REG_SELECT_B, {1'b0, sel[3], 1'b0, sel[2]});
        wr(REG_GATE_POL, {4'h0, pol});
        for (int g = 0; g < 4; g++) begin
            wr(4'(REG_GATE1_TERMS + g), terms[g]);
        end
        wr(REG_CONTROL, ctrl);
    endtask

    task automatic check_all();
        logic [3:0] el, eg;
        logic ce;
        logic [7:0] v;
        el = exp_lines(gin);
        for (int g = 0; g < 4; g++) begin
            eg[g] = exp_gate(g, el);
        end
        ce = ctrl[7] & exp_fn(ctrl[2:0], eg);
        `CHK(line, el)
        `CHK(gate, eg)
        `CHK(cell_out, ce)
        `CHK(cell_pin_out, ce)
        `CHK(cell_pin_oe, ctrl[6])
        `CHK(func_mode, plc_mode_t'(ctrl[2:0]))
        rd(REG_STATUS, v);
        `CHK(v, ({eg, el}))
        rd(REG_CONTROL, v);
        `CHK(v, ({ctrl[7:6], ce, 2'b00, ctrl[2:0]}))
    endtask

    task automatic stop_test();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------
    initial begin
        seed_val = $urandom(32'h5919F73B);
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(REG_CONTROL, d);
        `CHK(d, CTRL_RESET)
        rd(4'h9, d);
        `CHK(d, READ_UNMAPPED)
        for (int i = 0; i < 48; i++) begin
            for (int k = 0; k < 4; k++) begin
                sel[k] = 3'($urandom);
                terms[k] = 8'($urandom);
                if (i < 8) begin
                    sel[k] = 3'(i);
                end
            end
            pol = 4'($urandom);
            // Read-only and unused control bits are written too and must be ignored.
            ctrl = 8'($urandom);
            if (i < 8) begin
                terms[0] = pat[i % 4];
                terms[1] = 8'hAA;
                pol[0] = i[2];
                pol[1] = i[0];
            end
            cfg();
            rd(REG_SELECT_A, d);
            `CHK(d, ({1'b0, sel[1], 1'b0, sel[0]}))
            rd(REG_SELECT_B, d);
            `CHK(d, ({1'b0, sel[3], 1'b0, sel[2]}))
            rd(REG_GATE_POL, d);
            `CHK(d, ({4'h0, pol}))
            for (int g = 0; g < 4; g++) begin
                rd(4'(REG_GATE1_TERMS + g), d);
                `CHK(d, terms[g])
            end
            repeat (4) begin
                @(posedge sys_clk);
                gin <= 16'($urandom);
                @(negedge sys_clk);
                check_all();
            end
        end
        // Settings other than control must survive a reset.
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        ctrl = 8'h00;
        @(negedge sys_clk);
        check_all();
        stop_test();
    end

    initial begin
        repeat (50000) @(posedge sys_clk);
        n_mismatch++;
        stop_test();
    end
endmodule
